// >>> verilog/csc_status_config_regs.sv
// Core status word and setup word, with the mode and flag logic.
// Assumes all core events arrive as one-cycle pulses on mclk_in.
//
// Notes on behaviour
// - Carry set on add carry or sub borrow
// - Trace trap per instruction, off in handlers
// - Unsigned below flag from compare
// - User bit picks user stack pointer
// - Exception entry forces supervisor mode
// - User stack access traps in user mode
// - Only jump-to-user sets user mode
// - General flag reports add/sub overflow
// - Equal flag from compare
// - Signed below flag from compare
// - Enable/disable instructions drive local enable
// - Maskable irq needs both enables set
// - Pending copies trace at start, traps at end
// - Global enable cleared on irq, set on return
// - Branches evaluate held condition flags
// - Reset clears status except local enable
// - Warm reset copies old status out
// - Bits 4, 8, 12-15 read zero
// - Status changes only on affecting events
// - Setup word clears on reset
// - Vector entry width bit, base untouched
// - Short register compatibility mode bit
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module csc_status_config_regs #(
  parameter int DW = csc_pkg::CSC_DATA_W,   // Register width
  parameter int AW = csc_pkg::CSC_ADDR_W    // Address width
) (
  // Clock and resets
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 warm_rst_in,
  // Register port
  input  wire logic [AW-1:0]        reg_addr_in,
  input  wire logic [DW-1:0]        reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic      [DW-1:0]        reg_rdata_out,
  // Instruction events
  input  wire logic                 instr_start_in,
  input  wire logic                 instr_end_in,
  input  wire logic                 alu_valid_in,
  input  wire csc_pkg::csc_alu_op_e alu_op_in,
  input  wire logic [DW-1:0]        alu_a_in,
  input  wire logic [DW-1:0]        alu_b_in,
  input  wire logic                 f_wr_in,
  input  wire logic                 f_val_in,
  input  wire logic                 irq_on_in,
  input  wire logic                 irq_off_in,
  input  wire logic                 jump_user_in,
  input  wire logic                 usp_access_in,
  input  wire logic [3:0]           cond_code_in,
  // Exception events
  input  wire logic                 exc_entry_in,
  input  wire logic                 exc_is_irq_in,
  input  wire logic                 exc_return_in,
  input  wire logic                 ret_is_irq_in,
  input  wire logic [DW-1:0]        ret_psr_in,
  input  wire logic                 irq_req_in,
  input  wire logic                 nmi_req_in,
  // Register views
  output logic      [DW-1:0]        psr_out,
  output logic      [DW-1:0]        cfg_out,
  // Mode outputs
  output logic                      use_user_stack_out,
  output logic                      wide_vector_entries_out,
  output logic                      short_reg_compat_out,
  output logic                      maskable_ok_out,
  // Exception answers
  output logic                      irq_accept_out,
  output logic                      nmi_accept_out,
  output logic                      trace_trap_out,
  output logic                      illegal_op_trap_out,
  output logic                      usp_grant_out,
  output logic                      branch_taken_out,
  // Warm reset copy toward R2
  output logic                      r2_load_out,
  output logic      [DW-1:0]        r2_data_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [DW-1:0] psr_ff;      // Status word
  logic [DW-1:0] nxt_psr;
  logic [DW-1:0] cfg_ff;      // Setup word
  logic [DW-1:0] nxt_cfg;
  logic [DW-1:0] save_ff;     // Copy taken at warm reset
  logic [DW-1:0] rdata_ff;    // Read answer
  logic [DW-1:0] nxt_rdata;
  logic          r2_load_ff;  // Copy strobe toward R2

  csc_flag_if fl_if ();       // Flag bundle

  // ---------------------------------------------------------------
  // Flag computation
  // ---------------------------------------------------------------
  csc_flag_unit #(
    .W        (DW)
  ) u_flag (
    .valid_in (alu_valid_in),
    .op_in    (alu_op_in),
    .a_in     (alu_a_in),
    .b_in     (alu_b_in),
    .fl       (fl_if.alu)
  );

  // Held flags toward the condition unit
  assign fl_if.cur_c = psr_ff[csc_pkg::CSC_PSR_C];
  assign fl_if.cur_f = psr_ff[csc_pkg::CSC_PSR_F];
  assign fl_if.cur_l = psr_ff[csc_pkg::CSC_PSR_L];
  assign fl_if.cur_n = psr_ff[csc_pkg::CSC_PSR_N];
  assign fl_if.cur_z = psr_ff[csc_pkg::CSC_PSR_Z];

  // ---------------------------------------------------------------
  // Branch condition
  // ---------------------------------------------------------------
  csc_cond_unit u_cond (
    .code_in   (cond_code_in),
    .fl        (fl_if.cond),
    .taken_out (branch_taken_out)
  );

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  wire logic sel_psr  = reg_addr_in == csc_pkg::CSC_OFS_PSR;
  wire logic sel_cfg  = reg_addr_in == csc_pkg::CSC_OFS_CFG;
  wire logic sel_save = reg_addr_in == csc_pkg::CSC_OFS_SAVE;
  wire logic wr_psr   = reg_wr_in && sel_psr;   // Status write
  wire logic wr_cfg   = reg_wr_in && sel_cfg;   // Setup write

  // Read selection, unmapped reads return zero
  wire logic [DW-1:0] rd_mux =
      sel_psr  ? psr_ff  :
      sel_cfg  ? cfg_ff  :
      sel_save ? save_ff : '0;

  // ---------------------------------------------------------------
  // Mode and gate decode
  // ---------------------------------------------------------------
  wire logic psr_u = psr_ff[csc_pkg::CSC_PSR_U];
  wire logic psr_t = psr_ff[csc_pkg::CSC_PSR_T];
  wire logic psr_p = psr_ff[csc_pkg::CSC_PSR_P];
  wire logic psr_e = psr_ff[csc_pkg::CSC_PSR_E];
  wire logic psr_i = psr_ff[csc_pkg::CSC_PSR_I];

  // Pending seen at instruction end; a one-cycle
  // instruction takes the trace bit directly
  wire logic pend_eff   = instr_start_in ? psr_t : psr_p;
  wire logic trace_take = instr_end_in && pend_eff;

  // Both enables must be set for maskable requests
  wire logic mask_ok = psr_e && psr_i;

  // ---------------------------------------------------------------
  // Combinational answers toward the core
  // ---------------------------------------------------------------
  assign maskable_ok_out     = mask_ok;
  assign irq_accept_out      = irq_req_in && mask_ok;
  assign nmi_accept_out      = nmi_req_in;
  assign trace_trap_out      = trace_take;
  assign illegal_op_trap_out = usp_access_in && psr_u;
  assign usp_grant_out       = usp_access_in && !psr_u;
  assign use_user_stack_out  = psr_u;

  // ---------------------------------------------------------------
  // Setup word outputs
  // ---------------------------------------------------------------
  // Entry width only; the table base lives elsewhere
  assign wide_vector_entries_out = cfg_ff[csc_pkg::CSC_CFG_ED];
  assign short_reg_compat_out    = cfg_ff[csc_pkg::CSC_CFG_SR];

  // ---------------------------------------------------------------
  // Register views and read data
  // ---------------------------------------------------------------
  assign psr_out       = psr_ff;
  assign cfg_out       = cfg_ff;
  assign reg_rdata_out = rdata_ff;
  assign r2_load_out   = r2_load_ff;
  assign r2_data_out   = save_ff;

  // Read data stands only in the cycle after the strobe
  assign nxt_rdata = reg_rd_in ? rd_mux : '0;

  // ---------------------------------------------------------------
  // Next status word
  // ---------------------------------------------------------------
  // Later assignments win: core events override a
  // same-cycle port write, so hardware sets are kept.
  always_comb begin
    nxt_psr = psr_ff;  // Hold when nothing affects it
    // Port write; user bit may be cleared, never set
    if (wr_psr) begin
      nxt_psr = reg_wdata_in;
      nxt_psr[csc_pkg::CSC_PSR_U] =
          reg_wdata_in[csc_pkg::CSC_PSR_U] && psr_u;
    end
    // Carry and overflow from add or subtract
    if (fl_if.upd_cf) begin
      nxt_psr[csc_pkg::CSC_PSR_C] = fl_if.c_val;
      nxt_psr[csc_pkg::CSC_PSR_F] = fl_if.f_val;
    end
    // Compare results
    if (fl_if.upd_cmp) begin
      nxt_psr[csc_pkg::CSC_PSR_L] = fl_if.l_val;
      nxt_psr[csc_pkg::CSC_PSR_N] = fl_if.n_val;
      nxt_psr[csc_pkg::CSC_PSR_Z] = fl_if.z_val;
    end
    // Other users of the general flag
    if (f_wr_in) begin
      nxt_psr[csc_pkg::CSC_PSR_F] = f_val_in;
    end
    // Local enable instructions
    if (irq_on_in) begin
      nxt_psr[csc_pkg::CSC_PSR_E] = 1'b1;
    end else if (irq_off_in) begin
      nxt_psr[csc_pkg::CSC_PSR_E] = 1'b0;
    end
    // Enter user mode
    if (jump_user_in) begin
      nxt_psr[csc_pkg::CSC_PSR_U] = 1'b1;
    end
    // Trace pending copy and consumption
    if (instr_start_in) begin
      nxt_psr[csc_pkg::CSC_PSR_P] = psr_t;
    end
    if (trace_take) begin
      nxt_psr[csc_pkg::CSC_PSR_P] = 1'b0;
    end
    // Handler return restores flags, user bit stays
    if (exc_return_in) begin
      nxt_psr = ret_psr_in;
      nxt_psr[csc_pkg::CSC_PSR_U] = psr_u;
      if (ret_is_irq_in) begin
        nxt_psr[csc_pkg::CSC_PSR_I] = 1'b1;
      end
    end
    // Exception entry: supervisor, no tracing
    if (exc_entry_in) begin
      nxt_psr[csc_pkg::CSC_PSR_U] = 1'b0;
      nxt_psr[csc_pkg::CSC_PSR_T] = 1'b0;
      nxt_psr[csc_pkg::CSC_PSR_P] = 1'b0;
      if (exc_is_irq_in) begin
        nxt_psr[csc_pkg::CSC_PSR_I] = 1'b0;
      end
    end
    // Constant and reserved bits forced to zero
    nxt_psr = nxt_psr & csc_pkg::CSC_PSR_MASK;
  end

  // ---------------------------------------------------------------
  // Next setup word
  // ---------------------------------------------------------------
  // Cache and other reserved bits never store
  assign nxt_cfg = wr_cfg ? (reg_wdata_in & csc_pkg::CSC_CFG_MASK)
                          : cfg_ff;

  // ---------------------------------------------------------------
  // Status word register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      psr_ff <= csc_pkg::CSC_PSR_RST;
    end else if (warm_rst_in) begin
      psr_ff <= csc_pkg::CSC_PSR_RST;
    end else begin
      psr_ff <= nxt_psr;
    end
  end

  // ---------------------------------------------------------------
  // Setup word register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_ff <= csc_pkg::CSC_CFG_RST;
    end else if (warm_rst_in) begin
      cfg_ff <= csc_pkg::CSC_CFG_RST;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // ---------------------------------------------------------------
  // Warm reset copy of the old status word
  // ---------------------------------------------------------------
  // Cold reset has no old value to keep
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      save_ff    <= '0;
      r2_load_ff <= 1'b0;
    end else begin
      if (warm_rst_in) begin
        save_ff <= psr_ff;
      end
      r2_load_ff <= warm_rst_in;
    end
  end

  // ---------------------------------------------------------------
  // Read data register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
endmodule

// >>> shared/csc_pkg.sv
// Constants and types for the core status and setup registers.
// Assumes one core clock; all users reference names as csc_pkg::name.
package csc_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int CSC_DATA_W = 16;            // Register width
  localparam int CSC_ADDR_W = 8;             // Register port address
  localparam int CSC_CC_W   = 4;             // Condition code width
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CSC_OFS_PSR  = 8'h00; // Status word
  localparam logic [7:0] CSC_OFS_CFG  = 8'h04; // Setup word
  localparam logic [7:0] CSC_OFS_SAVE = 8'h08; // Warm reset copy
  // ---------------------------------------------------------------
  // Status word bit positions
  // ---------------------------------------------------------------
  localparam int CSC_PSR_C = 0;              // Carry / borrow
  localparam int CSC_PSR_T = 1;              // Trace enable
  localparam int CSC_PSR_L = 2;              // Unsigned below
  localparam int CSC_PSR_U = 3;              // User mode
  localparam int CSC_PSR_F = 5;              // General flag
  localparam int CSC_PSR_Z = 6;              // Equal
  localparam int CSC_PSR_N = 7;              // Signed below
  localparam int CSC_PSR_E = 9;              // Local irq enable
  localparam int CSC_PSR_P = 10;             // Trace pending
  localparam int CSC_PSR_I = 11;             // Global irq enable
  localparam logic [15:0] CSC_PSR_MASK = 16'h0EEF; // Live bits
  localparam logic [15:0] CSC_PSR_RST  = 16'h0200; // Only E set
  // ---------------------------------------------------------------
  // Setup word bit positions
  // ---------------------------------------------------------------
  localparam int CSC_CFG_ED = 8;             // Wide vector entries
  localparam int CSC_CFG_SR = 9;             // Short register mode
  localparam logic [15:0] CSC_CFG_MASK = 16'h0300; // Live bits
  localparam logic [15:0] CSC_CFG_RST  = 16'h0000; // All clear
  // ---------------------------------------------------------------
  // Condition codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CSC_CC_EQ = 4'h0, CSC_CC_NE = 4'h1;
  localparam logic [3:0] CSC_CC_CS = 4'h2, CSC_CC_CC = 4'h3;
  localparam logic [3:0] CSC_CC_HI = 4'h4, CSC_CC_LS = 4'h5;
  localparam logic [3:0] CSC_CC_GT = 4'h6, CSC_CC_LE = 4'h7;
  localparam logic [3:0] CSC_CC_FS = 4'h8, CSC_CC_FC = 4'h9;
  localparam logic [3:0] CSC_CC_LO = 4'hA, CSC_CC_HS = 4'hB;
  localparam logic [3:0] CSC_CC_LT = 4'hC, CSC_CC_GE = 4'hD;
  localparam logic [3:0] CSC_CC_UC = 4'hE;
  // ---------------------------------------------------------------
  // Arithmetic operation kinds
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CSC_OP_NONE, CSC_OP_ADD, CSC_OP_SUB, CSC_OP_CMP
  } csc_alu_op_e;
endpackage

// >>> shared/csc_flag_if.sv
// Flag update and flag state bundle between the register block parts.
// Assumes all parts sit on the core clock.
`timescale 1ns/1ns
interface csc_flag_if;
  logic upd_cf;   // Carry and overflow update
  logic upd_cmp;  // Compare flags update
  logic c_val;    // New carry
  logic f_val;    // New overflow
  logic l_val;    // New unsigned below
  logic n_val;    // New signed below
  logic z_val;    // New equal
  logic cur_c;    // Held flags
  logic cur_f;
  logic cur_l;
  logic cur_n;
  logic cur_z;
  modport alu  (output upd_cf, upd_cmp, c_val, f_val, l_val, n_val, z_val);
  modport core (input upd_cf, upd_cmp, c_val, f_val, l_val, n_val, z_val,
                output cur_c, cur_f, cur_l, cur_n, cur_z);
  modport cond (input cur_c, cur_f, cur_l, cur_n, cur_z);
endinterface

// >>> verilog/csc_flag_unit.sv
// Flag computation for add, subtract and compare results.
// Assumes operands are valid in the cycle the op is presented.
`timescale 1ns/1ns
module csc_flag_unit #(
  parameter int W = 16                      // Operand width
) (
  // Operation
  input  wire logic                     valid_in,
  input  wire csc_pkg::csc_alu_op_e     op_in,
  input  wire logic [W-1:0]             a_in,
  input  wire logic [W-1:0]             b_in,
  // Flag results
  csc_flag_if.alu                       fl
);
  // ---------------------------------------------------------------
  // Arithmetic, result in the second operand
  // ---------------------------------------------------------------
  wire logic [W:0] sum  = {1'b0, b_in} + {1'b0, a_in};
  wire logic [W:0] diff = {1'b0, b_in} - {1'b0, a_in};
  wire logic       is_add = valid_in && (op_in == csc_pkg::CSC_OP_ADD);
  wire logic       is_sub = valid_in && (op_in == csc_pkg::CSC_OP_SUB);
  wire logic       add_ov = (a_in[W-1] == b_in[W-1]) && (sum[W-1] != b_in[W-1]);
  wire logic       sub_ov = (a_in[W-1] != b_in[W-1]) && (diff[W-1] != b_in[W-1]);
  // Carry or borrow, and overflow
  assign fl.upd_cf  = is_add || is_sub;
  assign fl.c_val   = is_add ? sum[W] : diff[W];
  assign fl.f_val   = is_add ? add_ov : sub_ov;
  // ---------------------------------------------------------------
  // Compare: second operand against first
  // ---------------------------------------------------------------
  assign fl.upd_cmp = valid_in && (op_in == csc_pkg::CSC_OP_CMP);
  assign fl.l_val   = b_in < a_in;
  assign fl.n_val   = $signed(b_in) < $signed(a_in);
  assign fl.z_val   = b_in == a_in;
endmodule

// >>> verilog/csc_cond_unit.sv
// Branch condition evaluation from the held flags.
// Assumes the code is stable while the answer is used.
`timescale 1ns/1ns
module csc_cond_unit (
  // Condition request
  input  wire logic [3:0] code_in,
  csc_flag_if.cond        fl,
  // Answer
  output logic            taken_out
);
  // ---------------------------------------------------------------
  // Code decode
  // ---------------------------------------------------------------
  always_comb begin
    case (code_in)
      csc_pkg::CSC_CC_EQ: taken_out = fl.cur_z;
      csc_pkg::CSC_CC_NE: taken_out = !fl.cur_z;
      csc_pkg::CSC_CC_CS: taken_out = fl.cur_c;
      csc_pkg::CSC_CC_CC: taken_out = !fl.cur_c;
      csc_pkg::CSC_CC_HI: taken_out = fl.cur_l;
      csc_pkg::CSC_CC_LS: taken_out = !fl.cur_l;
      csc_pkg::CSC_CC_GT: taken_out = fl.cur_n;
      csc_pkg::CSC_CC_LE: taken_out = !fl.cur_n;
      csc_pkg::CSC_CC_FS: taken_out = fl.cur_f;
      csc_pkg::CSC_CC_FC: taken_out = !fl.cur_f;
      csc_pkg::CSC_CC_LO: taken_out = !fl.cur_z && !fl.cur_l;
      csc_pkg::CSC_CC_HS: taken_out = fl.cur_z || fl.cur_l;
      csc_pkg::CSC_CC_LT: taken_out = !fl.cur_z && !fl.cur_n;
      csc_pkg::CSC_CC_GE: taken_out = fl.cur_z || fl.cur_n;
      csc_pkg::CSC_CC_UC: taken_out = 1'b1;
      default:            taken_out = 1'b0;  // Code 4'hF, not taken
    endcase
  end
endmodule

// >>> test/csc_sva.sv
// Property checker for the status and setup register block.
// Assumes it is bound to csc_status_config_regs; one clock domain.
`timescale 1ns/1ns
module csc_sva (
  // Clock and resets
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        warm_rst_in,
  // Core events
  input wire logic        instr_start_in,
  input wire logic        instr_end_in,
  input wire logic        irq_on_in,
  input wire logic        jump_user_in,
  input wire logic        usp_access_in,
  input wire logic        exc_entry_in,
  input wire logic        exc_is_irq_in,
  input wire logic        exc_return_in,
  input wire logic        ret_is_irq_in,
  input wire logic        irq_req_in,
  // Design answers
  input wire logic [15:0] psr_out,
  input wire logic [15:0] cfg_out,
  input wire logic        irq_accept_out,
  input wire logic        trace_trap_out,
  input wire logic        illegal_op_trap_out,
  input wire logic        usp_grant_out,
  input wire logic        r2_load_out,
  input wire logic [15:0] r2_data_out
);
  // ----------
  // Timing frame
  // ----------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_warm;
    warm_rst_in;
  endsequence
  sequence s_start;
    instr_start_in && !instr_end_in && !exc_entry_in && !exc_return_in && !warm_rst_in;
  endsequence
  // ----------
  // Properties
  // ----------
  AST_WARM: assert property (s_warm |=> r2_load_out
    && r2_data_out == $past(psr_out) && psr_out == 16'h0200) else $error("warm reset copy wrong");
  AST_PCOPY: assert property (s_start |=> psr_out[10] == $past(psr_out[1]))
    else $error("pending bit not copied");
  AST_TRAP: assert property (instr_end_in && !instr_start_in
    |-> trace_trap_out == psr_out[10]) else $error("trace trap wrong");
  AST_ZERO: assert property ((psr_out & 16'hF110) == 0
    && (cfg_out & 16'hFCFF) == 0) else $error("fixed bits not zero");
  AST_USP: assert property (usp_access_in |-> illegal_op_trap_out == psr_out[3]
    && usp_grant_out == !psr_out[3]) else $error("user stack access wrong");
  AST_IRQ: assert property (irq_req_in
    |-> irq_accept_out == (psr_out[9] && psr_out[11])) else $error("maskable accept wrong");
  AST_ENTRY: assert property (exc_entry_in && !warm_rst_in
    |=> !psr_out[3] && !psr_out[1]) else $error("entry left user mode");
  AST_GIE: assert property (exc_entry_in && exc_is_irq_in && !warm_rst_in
    |=> !psr_out[11]) else $error("global enable not cleared");
  AST_GRET: assert property (exc_return_in && ret_is_irq_in
    && !exc_entry_in && !warm_rst_in |=> psr_out[11]) else $error("global enable not restored");
  AST_EI: assert property (irq_on_in && !exc_return_in && !warm_rst_in |=> psr_out[9])
    else $error("local enable not set");
  AST_USET: assert property ($rose(psr_out[3]) |-> $past(jump_user_in))
    else $error("user mode without jump");
endmodule
bind csc_status_config_regs csc_sva csc_sva_i (.*);

// >>> test/test_csc_status_config_regs.sv
// Self-checking bench for the status and setup register block.
// Assumes csc_pkg, the design and its checker are compiled first.
`timescale 1ns/1ns
module test_csc_status_config_regs;
  // ----------
  // Signals
  // ----------
  logic        mclk_in, rst_n_in, reg_wr_in, reg_rd_in;
  logic [7:0]  reg_addr_in;
  logic [15:0] reg_wdata_in, alu_a_in, alu_b_in, ret_psr_in, ev;
  logic [3:0]  cond_code_in;
  logic [4:0]  snap;                     // Comb answers in pulse cycle
  int          mismatches, checked;
  csc_pkg::csc_alu_op_e alu_op_in;
  logic [15:0] reg_rdata_out, psr_out, cfg_out, r2_data_out;
  logic        use_user_stack_out, wide_vector_entries_out, short_reg_compat_out;
  logic        maskable_ok_out, irq_accept_out, nmi_accept_out, trace_trap_out;
  logic        illegal_op_trap_out, usp_grant_out, branch_taken_out, r2_load_out;
  // Event vector bits
  wire instr_start_in = ev[0], instr_end_in = ev[1], alu_valid_in = ev[2];
  wire irq_on_in = ev[3], irq_off_in = ev[4], jump_user_in = ev[5];
  wire exc_entry_in = ev[6], exc_return_in = ev[7], warm_rst_in = ev[8];
  wire usp_access_in = ev[9], f_wr_in = ev[10], f_val_in = ev[11];
  wire irq_req_in = ev[12], nmi_req_in = ev[13], exc_is_irq_in = ev[14];
  wire ret_is_irq_in = ev[15];
  csc_status_config_regs csc_status_config_regs_i (.*);
  // Clock
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  // ----------
  // Shared tasks
  // ----------
  task automatic chk(input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %0t %h %h", $time, s, e);
    end
  endtask
  // One-cycle event with optional ALU operands
  task automatic go(input logic [15:0] e, input csc_pkg::csc_alu_op_e o = csc_pkg::CSC_OP_NONE,
                    input logic [15:0] x = 16'h0000, y = 16'h0000);
    @(posedge mclk_in);
    ev <= e;
    alu_op_in <= o;
    alu_a_in <= x;
    alu_b_in <= y;
    #1 snap = {irq_accept_out, nmi_accept_out, trace_trap_out, illegal_op_trap_out, usp_grant_out};
    @(posedge mclk_in);
    ev <= 16'h0000;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, e);
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_regs;
    rd(8'h00, 16'h0200);
    rd(8'h04, 16'h0000);
    rd(8'h10, 16'h0000);
    wr(8'h04, 16'hFFFF);
    rd(8'h04, 16'h0300);
    @(posedge mclk_in);
    #1 chk(reg_rdata_out, 16'h0000);
    chk(16'({wide_vector_entries_out, short_reg_compat_out}), 16'h0003);
    wr(8'h00, 16'hFFFF);
    rd(8'h00, 16'h0EE7);
    wr(8'h00, 16'h0A00);
  endtask
  task automatic t_alu;
    go(16'h0004, csc_pkg::CSC_OP_CMP, 16'h0005, 16'h0003);
    chk(psr_out & 16'h00C4, 16'h0084);
    go(16'h0004, csc_pkg::CSC_OP_CMP, 16'hFFFF, 16'h0001);
    chk(psr_out & 16'h00C4, 16'h0004);
    go(16'h0004, csc_pkg::CSC_OP_CMP, 16'h0003, 16'h0003);
    chk(psr_out & 16'h00C4, 16'h0040);
    @(posedge mclk_in);
    cond_code_in <= csc_pkg::CSC_CC_EQ;
    #1 chk(16'(branch_taken_out), 16'h0001);
    @(posedge mclk_in);
    cond_code_in <= csc_pkg::CSC_CC_NE;
    #1 chk(16'(branch_taken_out), 16'h0000);
    go(16'h0004, csc_pkg::CSC_OP_ADD, 16'hFFFF, 16'h0001);
    chk(psr_out & 16'h0021, 16'h0001);
    go(16'h0004, csc_pkg::CSC_OP_ADD, 16'h0001, 16'h7FFF);
    chk(psr_out & 16'h0021, 16'h0020);
    go(16'h0004, csc_pkg::CSC_OP_SUB, 16'h0001, 16'h0000);
    go(16'h0000);
    chk(psr_out, 16'h0A41);
    @(posedge mclk_in);
    cond_code_in <= csc_pkg::CSC_CC_CS;
    #1 chk(16'(branch_taken_out), 16'h0001);
    @(posedge mclk_in);
    cond_code_in <= csc_pkg::CSC_CC_LO;
    #1 chk(16'(branch_taken_out), 16'h0000);
  endtask
  task automatic t_irq_mode;
    go(16'h0010);
    chk(psr_out, 16'h0841);
    chk(16'(maskable_ok_out), 16'h0000);
    go(16'h3000);
    chk(16'(snap[4:3]), 16'h0001);
    go(16'h0008);
    chk(16'(maskable_ok_out), 16'h0001);
    go(16'h1000);
    chk(16'(snap[4]), 16'h0001);
    go(16'h0020);
    chk(16'(use_user_stack_out), 16'h0001);
    go(16'h0200);
    chk(16'(snap[1:0]), 16'h0002);
    go(16'h4040);
    chk(psr_out, 16'h0241);
    chk(16'(use_user_stack_out), 16'h0000);
    go(16'h0200);
    chk(16'(snap[1:0]), 16'h0001);
    go(16'h8080);
    chk(psr_out, 16'h0A00);
  endtask
  task automatic t_trace_warm;
    wr(8'h00, 16'h0A02);
    go(16'h0001);
    chk(16'(psr_out[10]), 16'h0001);
    go(16'h0002);
    chk(16'({snap[2], psr_out[10]}), 16'h0002);
    go(16'h0040);
    go(16'h0003);
    chk(16'(snap[2]), 16'h0000);
    go(16'h0C00);
    chk(psr_out, 16'h0A20);
    wr(8'h04, 16'h0100);
    wr(8'h00, 16'h0A65);
    go(16'h0100);
    chk(psr_out, 16'h0200);
    chk(cfg_out, 16'h0000);
    chk(16'(r2_load_out), 16'h0001);
    chk(r2_data_out, 16'h0A65);
    rd(8'h08, 16'h0A65);
  endtask
  // ----------
  // Main sequence and watchdog
  // ----------
  initial begin
    {rst_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    {alu_a_in, alu_b_in, ev, cond_code_in} = '0;
    alu_op_in = csc_pkg::CSC_OP_NONE;
    ret_psr_in = 16'h0208;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_alu;
    t_irq_mode;
    t_trace_warm;
    report_and_stop;
  end
  initial begin
    #20000;
    mismatches++;
    report_and_stop;
  end
endmodule
